// >>> hw/rcss_pkg.sv
/*
 Package for the realtime CPU status snapshot block: APB register map,
 field positions, reset values, encodings and the snapshot carrier structs.
 Assumes a single 25 MHz clock domain shared by CPU taps and the APB slave.
*/
package rcss_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses, one aligned word each)
   localparam logic [7:0] RCSS_OFS_PC = 8'h00;
   localparam logic [7:0] RCSS_OFS_SR = 8'h04;
   localparam logic [7:0] RCSS_OFS_FLOAT_STATUS_CONTROL = 8'h08;
   localparam logic [7:0] RCSS_OFS_INTERRUPT_EVENT_CODE = 8'h0C;
   localparam logic [7:0] RCSS_OFS_EXCEPTION_EVENT_CODE = 8'h10;
   localparam logic [7:0] RCSS_OFS_FREQ = 8'h14;
   localparam logic [7:0] RCSS_OFS_MMU = 8'h18;
   localparam logic [7:0] RCSS_OFS_CACHE = 8'h1C;
   localparam logic [7:0] RCSS_OFS_IBADDR = 8'h20;
   localparam logic [7:0] RCSS_OFS_EBADDR = 8'h24;
   localparam logic [7:0] RCSS_OFS_BSTATE = 8'h28;
   localparam logic [7:0] RCSS_OFS_PINS = 8'h2C;
   localparam logic [7:0] RCSS_OFS_CTRL = 8'h30;
   localparam logic [7:0] RCSS_OFS_STAT = 8'h34;

   ////////////////////////////////////////////////////////////////////////
   // Internal bus state word fields
   localparam int RCSS_IB_ACT = 3;
   localparam int RCSS_IB_WR = 2;
   // Internal bus width codes
   localparam logic [1:0] RCSS_W8 = 2'h0;
   localparam logic [1:0] RCSS_W16 = 2'h1;
   localparam logic [1:0] RCSS_W32 = 2'h2;
   localparam logic [1:0] RCSS_W64 = 2'h3;

   // External bus state word fields
   localparam int RCSS_EB_ACT = 0;
   localparam int RCSS_EB_WR = 1;
   localparam int RCSS_EB_U0 = 2;
   localparam int RCSS_EB_U1 = 3;
   localparam int RCSS_EB_DMA = 4;
   localparam int RCSS_EB_STEAL = 5;
   localparam int RCSS_EB_U2 = 6;

   // Packed field positions inside the bus state, status, control and MMU registers
   localparam int RCSS_BS_EB_LSB = 8;
   localparam int RCSS_ST_MATCH = 0;
   localparam int RCSS_ST_VALID = 1;
   localparam int RCSS_ST_SLEEP = 2;
   localparam int RCSS_ST_RESET = 3;
   localparam int RCSS_CTRL_FREEZE = 0;
   localparam int RCSS_MMU_AT = 8;

   // Reset values
   localparam logic [31:0] RCSS_RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RCSS_RST_IB = 4'h0;
   localparam logic [6:0] RCSS_RST_EB = 7'h00;

   ////////////////////////////////////////////////////////////////////////
   // Snapshot carriers
   typedef struct packed {
      logic [31:0] pc;
      logic [31:0] sr;
      logic [31:0] float_status_control;
      logic [31:0] interrupt_event_code;
      logic [31:0] exception_event_code;
      logic [31:0] cache;
      logic at;
      logic [7:0] address_space_identifier;
   } rcss_core_s;

   typedef struct packed {
      logic [3:0] ib_state;
      logic [31:0] ib_addr;
      logic [6:0] eb_state;
      logic [31:0] eb_addr;
   } rcss_bus_s;

   typedef enum logic [2:0] {
      RCSS_RUN = 3'b001,
      RCSS_HALT = 3'b010,
      RCSS_SLEEP = 3'b100
   } rcss_mode_e;

endpackage : rcss_pkg

// >>> hw/rcss_snapshot.sv
/*
 Realtime CPU status snapshot: samples CPU registers, internal and external
 bus state, status pins and the channel A match flag into a frame that an
 emulator host reads over APB.
 Assumes the CPU taps are synchronous to i_clk and the host polls the block.
*/
// The APB register port and the register addresses were chosen for this implementation.
// Summary of operation
// RULE1: Capture valid only while user program runs
// RULE2: Data during CPU reset is not guaranteed
// RULE3: Sleep: only status pins and frequency readable
// RULE4: Host refreshes view every 100 ms
// RULE5: Internal bit3 marks access; else invalid
// RULE6: Internal bit2: zero read, one write
// RULE7: Internal bits1:0 encode access width
// RULE8: External bit5: burst or cycle steal
// RULE9: External bit4: processor or DMA master
// RULE10: External bits 6,3,2 encode DMA unit
// RULE11: Unit code reflects on-chip access size
// RULE12: External bit1: zero read, one write
// RULE13: External bit0 marks access; else invalid
// RULE14: Processor master makes bits 5,6 invalid
// RULE15: Capture internal and external bus addresses
// RULE16: Capture PC and control registers listed
// RULE17: Capture two-bit status output pins
// RULE18: Match flag set once channel A hits
// RULE19: Read returns value sampled at command
// RULE20: State word and address sampled together
module rcss_snapshot
   import rcss_pkg::*;
(
   input wire logic i_clk, // 25 MHz clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic [31:0] o_prdata, // APB read data
   output logic o_pready, // APB ready
   output logic o_pslverr, // APB error
   input wire rcss_pkg::rcss_core_s i_core, // CPU register taps
   input wire rcss_pkg::rcss_bus_s i_bus, // Bus taps
   input wire logic [31:0] i_freq, // Frequency control register
   input wire logic [1:0] i_status_pins, // Processor status pins
   input wire logic i_cha_match, // Break channel A satisfied pulse
   input wire logic i_prog_run, // User program executing
   input wire logic i_cpu_reset, // CPU held in reset
   input wire logic i_sleep // Sleep or deep sleep
);
   import rcss_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode and state registers
   rcss_mode_e mode_reg, mode_next; // Capture mode
   rcss_core_s core_reg; // Sampled CPU registers
   rcss_bus_s bus_reg; // Sampled bus words
   logic [31:0] freq_reg; // Sampled frequency control
   logic [1:0] pins_reg; // Sampled status pins
   logic match_reg; // Channel A sticky match
   logic freeze_reg; // Software freeze of the snapshot
   logic [31:0] prdata_reg; // Read data register
   logic rst_seen_reg; // CPU reset seen in sampled frame

   // Fold the external word: DMA-only bits cleared for processor access
   function automatic logic [6:0] rcss_eb_clean(input logic [6:0] w);
      logic [6:0] r;
      r = w;
      if (!w[RCSS_EB_ACT]) begin // RULE13
         r = RCSS_RST_EB;
      end else if (!w[RCSS_EB_DMA]) begin // RULE14
         r[RCSS_EB_STEAL] = 1'b0; // RULE8
         r[RCSS_EB_U2] = 1'b0;
      end
      return r;
   endfunction : rcss_eb_clean

   // Internal word: inactive access leaves nothing meaningful
   function automatic logic [3:0] rcss_ib_clean(input logic [3:0] w);
      return w[RCSS_IB_ACT] ? w : RCSS_RST_IB; // RULE5
   endfunction : rcss_ib_clean

   ////////////////////////////////////////////////////////////////////////
   // Mode selection: sleep beats run beats halt
   always_comb begin
      if (i_sleep) begin
         mode_next = RCSS_SLEEP; // RULE3
      end else if (i_prog_run) begin
         mode_next = RCSS_RUN; // RULE1
      end else begin
         mode_next = RCSS_HALT;
      end
   end

   wire take_core = (mode_next == RCSS_RUN) && !freeze_reg; // Full sampling
   wire take_pins = (mode_next != RCSS_HALT) && !freeze_reg; // Sleep subset

   // Mode register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_reg <= RCSS_HALT;
      end else begin
         mode_reg <= mode_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core register and bus sampling, one cycle, one frame
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         core_reg <= '0;
         bus_reg <= '0;
         rst_seen_reg <= 1'b0;
      end else if (take_core) begin
         core_reg <= i_core; // RULE16
         bus_reg.ib_state <= rcss_ib_clean(i_bus.ib_state); // RULE20 RULE6 RULE7
         bus_reg.ib_addr <= i_bus.ib_state[RCSS_IB_ACT] ? i_bus.ib_addr : RCSS_RST_WORD; // RULE15
         bus_reg.eb_state <= rcss_eb_clean(i_bus.eb_state); // RULE20 RULE9 RULE10 RULE11 RULE12
         bus_reg.eb_addr <= i_bus.eb_state[RCSS_EB_ACT] ? i_bus.eb_addr : RCSS_RST_WORD; // RULE15
         rst_seen_reg <= i_cpu_reset; // RULE2
      end
   end

   // Subset that stays readable in sleep
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         freq_reg <= RCSS_RST_WORD;
         pins_reg <= 2'h0;
      end else if (take_pins) begin
         freq_reg <= i_freq; // RULE3
         pins_reg <= i_status_pins; // RULE17
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel A match: sticky; a hit on the clearing write still wins
   wire ctrl_wr = i_psel && i_penable && i_pwrite && (i_paddr == RCSS_OFS_CTRL);
   wire stat_wr = i_psel && i_penable && i_pwrite && (i_paddr == RCSS_OFS_STAT);
   wire clr_match = stat_wr && i_pwdata[RCSS_ST_MATCH];

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         match_reg <= 1'b0;
      end else if (i_cha_match) begin
         match_reg <= 1'b1; // RULE18
      end else if (clr_match) begin
         match_reg <= 1'b0;
      end
   end

   // Freeze control lets the host hold one coherent frame across reads
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         freeze_reg <= 1'b0;
      end else if (ctrl_wr) begin
         freeze_reg <= i_pwdata[RCSS_CTRL_FREEZE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode; frame valid only in run mode, sleep hides core items
   wire frame_ok = (mode_reg == RCSS_RUN); // RULE1
   wire [31:0] core_or_zero_mask = frame_ok ? 32'hFFFF_FFFF : 32'h0000_0000; // RULE3
   wire [31:0] mmu_word = {23'h00_0000, core_reg.at, core_reg.address_space_identifier};
   wire [31:0] bstate_word = {17'h0_0000, bus_reg.eb_state, 4'h0, bus_reg.ib_state};
   wire [31:0] stat_word = {28'h000_0000, rst_seen_reg, mode_reg == RCSS_SLEEP,
                            frame_ok, match_reg};
   wire rd_hit = i_psel && !i_penable && !i_pwrite;
   logic [31:0] rd_mux; // Selected read word
   logic rd_bad; // Unmapped read address

   always_comb begin
      rd_bad = 1'b0;
      unique case (i_paddr)
         RCSS_OFS_PC: rd_mux = core_reg.pc & core_or_zero_mask;
         RCSS_OFS_SR: rd_mux = core_reg.sr & core_or_zero_mask;
         RCSS_OFS_FLOAT_STATUS_CONTROL: rd_mux = core_reg.float_status_control & core_or_zero_mask;
         RCSS_OFS_INTERRUPT_EVENT_CODE: rd_mux = core_reg.interrupt_event_code & core_or_zero_mask;
         RCSS_OFS_EXCEPTION_EVENT_CODE: rd_mux = core_reg.exception_event_code & core_or_zero_mask;
         RCSS_OFS_FREQ: rd_mux = freq_reg;
         RCSS_OFS_MMU: rd_mux = mmu_word & core_or_zero_mask;
         RCSS_OFS_CACHE: rd_mux = core_reg.cache & core_or_zero_mask;
         RCSS_OFS_IBADDR: rd_mux = bus_reg.ib_addr & core_or_zero_mask;
         RCSS_OFS_EBADDR: rd_mux = bus_reg.eb_addr & core_or_zero_mask;
         RCSS_OFS_BSTATE: rd_mux = bstate_word & core_or_zero_mask;
         RCSS_OFS_PINS: rd_mux = {30'h0000_0000, pins_reg};
         RCSS_OFS_CTRL: rd_mux = {31'h0000_0000, freeze_reg};
         RCSS_OFS_STAT: rd_mux = stat_word;
         default: begin
            rd_mux = RCSS_RST_WORD;
            rd_bad = 1'b1;
         end
      endcase
   end

   // Read data latched in the setup cycle: value as at command arrival
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prdata_reg <= RCSS_RST_WORD;
      end else if (rd_hit) begin
         prdata_reg <= rd_mux; // RULE19
      end
   end

   // Refused write detection: any address other than CTRL and STAT
   logic wr_bad;
   always_comb begin
      wr_bad = !(i_paddr == RCSS_OFS_CTRL || i_paddr == RCSS_OFS_STAT);
   end

   assign o_prdata = prdata_reg;
   assign o_pready = 1'b1; // Zero wait states in the access phase
   assign o_pslverr = i_psel && i_penable && (i_pwrite ? wr_bad : rd_bad);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_read_setup;
      i_psel && !i_penable && !i_pwrite && i_paddr == RCSS_OFS_STAT;
   endsequence

   property p_read_sample;
      @(posedge i_clk) disable iff (!i_rstn)
      s_read_setup |=> o_prdata == $past(stat_word);
   endproperty
   a_read_sample: assert property (p_read_sample) else $error("read not sampled at setup"); // RULE19

   property p_match_set;
      @(posedge i_clk) disable iff (!i_rstn)
      i_cha_match |=> match_reg;
   endproperty
   a_match_set: assert property (p_match_set) else $error("channel A match lost"); // RULE18

   property p_halt_freeze;
      @(posedge i_clk) disable iff (!i_rstn)
      (!i_prog_run && !i_sleep) |=> $stable(core_reg);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze) else $error("sampled during break"); // RULE1

   property p_sleep_hide;
      @(posedge i_clk) disable iff (!i_rstn)
      (mode_reg == RCSS_SLEEP && i_psel && !i_penable && !i_pwrite && i_paddr == RCSS_OFS_PC)
         |=> o_prdata == RCSS_RST_WORD;
   endproperty
   a_sleep_hide: assert property (p_sleep_hide) else $error("core item visible in sleep"); // RULE3

   property p_ib_invalid;
      @(posedge i_clk) disable iff (!i_rstn)
      (take_core && !i_bus.ib_state[RCSS_IB_ACT]) |=> bus_reg.ib_addr == RCSS_RST_WORD;
   endproperty
   a_ib_invalid: assert property (p_ib_invalid) else $error("idle internal addr kept"); // RULE5

   property p_ib_pair;
      @(posedge i_clk) disable iff (!i_rstn)
      (take_core && i_bus.ib_state[RCSS_IB_ACT])
         |=> bus_reg.ib_addr == $past(i_bus.ib_addr) && bus_reg.ib_state == $past(i_bus.ib_state);
   endproperty
   a_ib_pair: assert property (p_ib_pair) else $error("internal word split"); // RULE20

   property p_eb_idle;
      @(posedge i_clk) disable iff (!i_rstn)
      (take_core && !i_bus.eb_state[RCSS_EB_ACT]) |=> bus_reg.eb_state == RCSS_RST_EB;
   endproperty
   a_eb_idle: assert property (p_eb_idle) else $error("idle external word kept"); // RULE13

   property p_cpu_master;
      @(posedge i_clk) disable iff (!i_rstn)
      (take_core && i_bus.eb_state[RCSS_EB_ACT] && !i_bus.eb_state[RCSS_EB_DMA])
         |=> !bus_reg.eb_state[RCSS_EB_STEAL] && !bus_reg.eb_state[RCSS_EB_U2];
   endproperty
   a_cpu_master: assert property (p_cpu_master) else $error("DMA bits on CPU access"); // RULE14

   property p_pins_sleep;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_sleep && !freeze_reg) |=> pins_reg == $past(i_status_pins);
   endproperty
   a_pins_sleep: assert property (p_pins_sleep) else $error("pins not sampled in sleep"); // RULE17

   ////////////////////////////////////////////////////////////////////////
   // Field-by-field checks of the stored bus words; a pass-through slip
   // in one bit could hide behind a word-level check of another field
   sequence s_ib_take;
      take_core && i_bus.ib_state[RCSS_IB_ACT];
   endsequence

   sequence s_eb_take;
      take_core && i_bus.eb_state[RCSS_EB_ACT];
   endsequence

   // DMA-owned access: mode and unit bits are the only meaningful extras
   sequence s_eb_dma;
      take_core && i_bus.eb_state[RCSS_EB_ACT] && i_bus.eb_state[RCSS_EB_DMA];
   endsequence

   property p_ib_dir;
      @(posedge i_clk) disable iff (!i_rstn)
      s_ib_take |=> bus_reg.ib_state[RCSS_IB_WR] == $past(i_bus.ib_state[RCSS_IB_WR]);
   endproperty
   a_ib_dir: assert property (p_ib_dir) else $error("internal direction lost"); // RULE6

   property p_ib_width;
      @(posedge i_clk) disable iff (!i_rstn)
      s_ib_take |=> bus_reg.ib_state[RCSS_IB_WR-1:0] == $past(i_bus.ib_state[RCSS_IB_WR-1:0]);
   endproperty
   a_ib_width: assert property (p_ib_width) else $error("internal width lost"); // RULE7

   property p_eb_dir;
      @(posedge i_clk) disable iff (!i_rstn)
      s_eb_take |=> bus_reg.eb_state[RCSS_EB_WR] == $past(i_bus.eb_state[RCSS_EB_WR]);
   endproperty
   a_eb_dir: assert property (p_eb_dir) else $error("external direction lost"); // RULE12

   property p_eb_master;
      @(posedge i_clk) disable iff (!i_rstn)
      s_eb_take |=> bus_reg.eb_state[RCSS_EB_DMA] == $past(i_bus.eb_state[RCSS_EB_DMA]);
   endproperty
   a_eb_master: assert property (p_eb_master) else $error("bus master lost"); // RULE9

   property p_dma_mode;
      @(posedge i_clk) disable iff (!i_rstn)
      s_eb_dma |=> bus_reg.eb_state[RCSS_EB_STEAL] == $past(i_bus.eb_state[RCSS_EB_STEAL]);
   endproperty
   a_dma_mode: assert property (p_dma_mode) else $error("DMA mode lost"); // RULE8

   property p_dma_unit;
      @(posedge i_clk) disable iff (!i_rstn)
      s_eb_dma |=> bus_reg.eb_state[RCSS_EB_U2] == $past(i_bus.eb_state[RCSS_EB_U2])
         && bus_reg.eb_state[RCSS_EB_U1:RCSS_EB_U0] == $past(i_bus.eb_state[RCSS_EB_U1:RCSS_EB_U0]);
   endproperty
   a_dma_unit: assert property (p_dma_unit) else $error("DMA unit lost"); // RULE10 RULE11

   property p_eb_addr_idle;
      @(posedge i_clk) disable iff (!i_rstn)
      (take_core && !i_bus.eb_state[RCSS_EB_ACT]) |=> bus_reg.eb_addr == RCSS_RST_WORD;
   endproperty
   a_eb_addr_idle: assert property (p_eb_addr_idle) else $error("idle external addr kept"); // RULE13

   ////////////////////////////////////////////////////////////////////////
   // Sampling, sleep subset and CPU reset marker
   property p_core_sample;
      @(posedge i_clk) disable iff (!i_rstn)
      take_core |=> core_reg == $past(i_core);
   endproperty
   a_core_sample: assert property (p_core_sample) else $error("core registers not sampled"); // RULE16

   property p_freq_sleep;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_sleep && !freeze_reg) |=> freq_reg == $past(i_freq);
   endproperty
   a_freq_sleep: assert property (p_freq_sleep) else $error("frequency not sampled in sleep"); // RULE3

   property p_rst_seen;
      @(posedge i_clk) disable iff (!i_rstn)
      take_core |=> rst_seen_reg == $past(i_cpu_reset);
   endproperty
   a_rst_seen: assert property (p_rst_seen) else $error("CPU reset marker wrong"); // RULE2

   // A frozen frame must not move, or the host would see a mixed snapshot
   property p_freeze_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      freeze_reg |=> $stable(core_reg) && $stable(bus_reg);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("frozen frame changed"); // RULE20

   // Sticky flag: cleared only by the host, never lost on its own
   property p_match_clear;
      @(posedge i_clk) disable iff (!i_rstn)
      (clr_match && !i_cha_match) |=> !match_reg;
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match flag not cleared"); // RULE18

   property p_match_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      (match_reg && !clr_match) |=> match_reg;
   endproperty
   a_match_hold: assert property (p_match_hold) else $error("match flag dropped"); // RULE18

endmodule : rcss_snapshot

// >>> bench/rcss_host_probe.sv
/*
 Emulator host probe model: an APB master that reads status snapshots.
 Assumes its task is called just after a rising edge of i_clk.
*/
module rcss_host_probe (
   input wire logic i_clk, // Bus clock
   output logic o_psel, // APB select
   output logic o_penable, // APB enable
   output logic o_pwrite, // APB direction
   output logic [7:0] o_paddr, // APB byte address
   output logic [31:0] o_pwdata, // APB write data
   input wire logic [31:0] i_prdata, // APB read data
   input wire logic i_pready, // APB ready
   input wire logic i_pslverr // APB error
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // One transfer; polled much faster than the real refresh pace
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= wd;
      @(posedge i_clk);
      o_penable <= 1'b1;
      // Hold the request until ready is seen; the bench timeout ends a hang
      do @(posedge i_clk); while (i_pready !== 1'b1);
      rd = i_prdata;
      er = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Stale write data must not look valid once released
      o_pwdata <= ~wd;
   endtask : xfer
endmodule : rcss_host_probe

// >>> bench/rcss_snapshot_tb.sv
/*
 Self-checking bench for the status snapshot block.
 Assumes rcss_pkg and the host probe model are compiled first.
*/
module rcss_snapshot_tb import rcss_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rstn, psel, penable, pwrite, pready, pslverr, er;
   logic prog_run, cpu_reset, sleep, cha_match;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, freq, d, keep;
   logic [1:0] pins;
   rcss_core_s core;
   rcss_bus_s bus;
   int bad_count, compares, cyc;

   rcss_snapshot rcss_snapshot_i (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_core(core),
      .i_bus(bus), .i_freq(freq), .i_status_pins(pins), .i_cha_match(cha_match),
      .i_prog_run(prog_run), .i_cpu_reset(cpu_reset), .i_sleep(sleep));

   rcss_host_probe rcss_host_probe_i (.i_clk(clk), .o_psel(psel), .o_penable(penable),
      .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
      .i_pready(pready), .i_pslverr(pslverr));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Expected bus state word: idle or processor-owned fields read as zero
   function automatic logic [31:0] exp_bs(input rcss_bus_s b);
      logic [3:0] ib;
      logic [6:0] eb;
      ib = b.ib_state[3] ? b.ib_state : 4'h0;
      eb = !b.eb_state[0] ? 7'h00 : (b.eb_state[4] ? b.eb_state : b.eb_state & 7'h1F);
      return {17'h0_0000, eb, 4'h0, ib};
   endfunction : exp_bs

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      rcss_host_probe_i.xfer(1'b0, a, 32'h0000_0000, d, er);
      chk(n, e, d);
   endtask : rd

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rstn = 1'b0;
      core = '0;
      bus = '0;
      freq = 32'h0000_0000;
      pins = 2'h0;
      {prog_run, cpu_reset, sleep, cha_match} = 4'h0;
      void'($urandom(71));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      // Halted after reset: core items stay hidden
      rd(RCSS_OFS_PC, 32'h0000_0000, "pc_halt");
      $display("test halt done");
      prog_run <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         core <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, 9'($urandom)};
         freq <= $urandom;
         pins <= 2'($urandom);
         repeat (2) @(posedge clk);
         rd(RCSS_OFS_PC, core.pc, "pc");
         rd(RCSS_OFS_SR, core.sr, "sr");
         rd(RCSS_OFS_FLOAT_STATUS_CONTROL, core.float_status_control, "float_status_control");
         rd(RCSS_OFS_INTERRUPT_EVENT_CODE, core.interrupt_event_code, "interrupt_event_code");
         rd(RCSS_OFS_EXCEPTION_EVENT_CODE, core.exception_event_code, "exception_event_code");
         rd(RCSS_OFS_CACHE, core.cache, "cache");
         rd(RCSS_OFS_MMU, {23'h00_0000, core.at, core.address_space_identifier}, "mmu");
         rd(RCSS_OFS_FREQ, freq, "freq");
         rd(RCSS_OFS_PINS, {30'h0000_0000, pins}, "pins");
      end
      $display("test core done");
      // Widths, units, masters and idle cases of both bus words
      for (int i = 0; i < 16; i++) begin
         bus <= {i[3] | i[2], 1'($urandom), 2'(i), $urandom, 6'($urandom), i[3:2] != 2'h0,
                 $urandom};
         repeat (2) @(posedge clk);
         rd(RCSS_OFS_BSTATE, exp_bs(bus), "bstate");
         rd(RCSS_OFS_IBADDR, bus.ib_state[3] ? bus.ib_addr : 32'h0000_0000, "ibaddr");
         rd(RCSS_OFS_EBADDR, bus.eb_state[0] ? bus.eb_addr : 32'h0000_0000, "ebaddr");
      end
      $display("test bus done");
      // Sticky match flag, then a write of one clears it
      cha_match <= 1'b1;
      @(posedge clk);
      cha_match <= 1'b0;
      rd(RCSS_OFS_STAT, 32'h0000_0003, "stat_match");
      rcss_host_probe_i.xfer(1'b1, RCSS_OFS_STAT, 32'h0000_0001, d, er);
      rd(RCSS_OFS_STAT, 32'h0000_0002, "stat_clear");
      $display("test match done");
      // CPU reset inside a captured frame is flagged; frame stays valid
      cpu_reset <= 1'b1;
      repeat (2) @(posedge clk);
      rd(RCSS_OFS_STAT, 32'h0000_000A, "stat_cpu_reset");
      cpu_reset <= 1'b0;
      $display("test cpu reset done");
      // Unmapped read and a write to a read-only place are refused
      rd(8'h40, 32'h0000_0000, "unmapped");
      chk("unmapped_err", 32'h0000_0001, {31'h0, er});
      rcss_host_probe_i.xfer(1'b1, RCSS_OFS_PC, 32'h0000_0005, d, er);
      chk("ro_err", 32'h0000_0001, {31'h0, er});
      rd(RCSS_OFS_PC, core.pc, "pc_kept");
      $display("test refusal done");
      // Freeze holds the frame; release lets the next one in
      rcss_host_probe_i.xfer(1'b1, RCSS_OFS_CTRL, 32'h0000_0001, d, er);
      rd(RCSS_OFS_CTRL, 32'h0000_0001, "ctrl_freeze");
      keep = core.pc;
      core.pc <= ~keep;
      repeat (2) @(posedge clk);
      rd(RCSS_OFS_PC, keep, "pc_frozen");
      rcss_host_probe_i.xfer(1'b1, RCSS_OFS_CTRL, 32'h0000_0000, d, er);
      rd(RCSS_OFS_PC, ~keep, "pc_thawed");
      $display("test freeze done");
      // Sleep: only pins and frequency follow
      sleep <= 1'b1;
      freq <= $urandom;
      pins <= ~pins;
      repeat (2) @(posedge clk);
      rd(RCSS_OFS_FREQ, freq, "freq_sleep");
      rd(RCSS_OFS_PINS, {30'h0000_0000, pins}, "pins_sleep");
      rd(RCSS_OFS_PC, 32'h0000_0000, "pc_sleep");
      rd(RCSS_OFS_STAT, 32'h0000_0004, "stat_sleep");
      $display("test sleep done");
      // Break: core items hidden again
      sleep <= 1'b0;
      prog_run <= 1'b0;
      repeat (2) @(posedge clk);
      rd(RCSS_OFS_SR, 32'h0000_0000, "sr_break");
      $display("test break done");
      stop_test();
   end
endmodule : rcss_snapshot_tb
